// ===== hw/edp_ctrl.sv
// Purpose: energy detect power control for one transceiver port
// Assumes: line event inputs are asynchronous level pulses from analog
// Notes: register port reads back one cycle after the read strobe
//
// How it works
// RL1 - Bit 15 enables energy detect, reset from the strap, read/write.
// RL2 - Software should turn off crossover when energy detect runs alone.
// RL3 - With bit 14 set, reaching the data threshold powers the port up.
// RL4 - With bit 13 set, losing energy on the line powers the port down.
// RL5 - Writing 1 to bit 12 flips the power state at once, then it clears.
// RL6 - Software may use bit 12 after clearing the interrupt to time it.
// RL7 - Each power-up sends 4 data pulses, or 1 when bit 11 is set.
// RL8 - Bit 10 reads 1 when powered up and 0 when powered down.
// RL9 - Bit 9 flags the error threshold met, informational, clear on read.
// RL10 - Bit 8 flags the data threshold met and clears on read.
// RL11 - Bits 7:4 hold the error event threshold, reset 1.
// RL12 - Bits 3:0 hold the data event threshold, reset 1.
// RL13 - Both counters reset after about 2 s without a data event.
// RL14 - The control register answers at address 1Dh.
// RL15 - While disabled the driver stays powered and no transitions occur.
`timescale 1ns/1ps
module edp_ctrl
  import edp_pkg::*;
#(
  parameter longint IDLE_CYC = EDP_IDLE_CYC
)
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic strap_en,
  input wire logic data_event_in,
  input wire logic error_event_in,
  input wire logic no_energy_in,
  input wire logic [4:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  output logic driver_power_on,
  output logic pulse_out,
  output logic irq
);
  // ---------------------------------------------------------------
  // Line input synchronisers
  // ---------------------------------------------------------------
  edp_line_t line_s;
  edp_sync u_sync_data (.clock(clock), .sys_rst(sys_rst),
    .async_in(data_event_in), .sync_out(line_s.data_ev));
  edp_sync u_sync_err (.clock(clock), .sys_rst(sys_rst),
    .async_in(error_event_in), .sync_out(line_s.err_ev));
  edp_sync u_sync_none (.clock(clock), .sys_rst(sys_rst),
    .async_in(no_energy_in), .sync_out(line_s.no_energy));

  logic data_d_ff;
  logic err_d_ff;
  logic data_pulse;
  logic err_pulse;
  // Events are rising edges of the filtered levels
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      data_d_ff <= 1'b0;
      err_d_ff <= 1'b0;
    end
    else
    begin
      data_d_ff <= line_s.data_ev;
      err_d_ff <= line_s.err_ev;
    end
  end
  assign data_pulse = line_s.data_ev & ~data_d_ff;
  assign err_pulse = line_s.err_ev & ~err_d_ff;

  // ---------------------------------------------------------------
  // Configuration register
  // ---------------------------------------------------------------
  edp_cfg_t cfg_ff;
  logic strap_take_ff;
  logic ctrl_wr;
  logic ctrl_rd;
  logic man_req;
  assign ctrl_wr = reg_wr && (reg_addr == EDP_ADDR_CTRL); // [RL14]
  assign ctrl_rd = reg_rd && (reg_addr == EDP_ADDR_CTRL); // [RL14]
  // Self-clearing manual bit never stored; a write acts as one pulse
  assign man_req = ctrl_wr && reg_wdata[EDP_BIT_MAN]; // [RL5]

  // Strap caught on the first clock after reset, not under reset
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      strap_take_ff <= 1'b1;
      cfg_ff.en <= 1'b0;
      cfg_ff.auto_up <= EDP_AUTO_UP_RST;
      cfg_ff.auto_down <= EDP_AUTO_DOWN_RST;
      cfg_ff.burst_dis <= 1'b0;
      cfg_ff.err_thr <= EDP_ERR_THR_RST; // [RL11]
      cfg_ff.data_thr <= EDP_DATA_THR_RST; // [RL12]
    end
    else
    begin
      strap_take_ff <= 1'b0;
      if (strap_take_ff)
        cfg_ff.en <= strap_en; // [RL1]
      else if (ctrl_wr)
        cfg_ff.en <= reg_wdata[EDP_BIT_EN]; // [RL1]
      if (ctrl_wr)
      begin
        cfg_ff.auto_up <= reg_wdata[EDP_BIT_AUTO_UP];
        cfg_ff.auto_down <= reg_wdata[EDP_BIT_AUTO_DOWN];
        cfg_ff.burst_dis <= reg_wdata[EDP_BIT_BURST_DIS];
        cfg_ff.err_thr <= reg_wdata[7:4]; // [RL11]
        cfg_ff.data_thr <= reg_wdata[3:0]; // [RL12]
      end
    end
  end

  // ---------------------------------------------------------------
  // Event counters and idle timer
  // ---------------------------------------------------------------
  logic [3:0] data_cnt_ff;
  logic [3:0] err_cnt_ff;
  logic [31:0] idle_ff;
  logic idle_done;
  logic data_reach;
  logic err_reach;
  assign idle_done = (idle_ff >= 32'(IDLE_CYC - 1));
  assign data_reach = data_pulse &&
    ({1'b0, data_cnt_ff} + 5'h1 >= {1'b0, cfg_ff.data_thr});
  assign err_reach = err_pulse &&
    ({1'b0, err_cnt_ff} + 5'h1 >= {1'b0, cfg_ff.err_thr});

  // Idle timer restarts on every data event
  always_ff @(posedge clock)
  begin
    if (sys_rst || data_pulse || !cfg_ff.en)
      idle_ff <= 32'h0;
    else if (!idle_done)
      idle_ff <= idle_ff + 32'h1;
    else
      idle_ff <= 32'h0; // [RL13]
  end

  // Counters saturate; cleared by idle timeout or a power transition
  logic go_up;
  logic go_down;
  always_ff @(posedge clock)
  begin
    if (sys_rst || idle_done || go_up || go_down || !cfg_ff.en)
    begin
      data_cnt_ff <= 4'h0; // [RL13]
      err_cnt_ff <= 4'h0; // [RL13]
    end
    else
    begin
      if (data_pulse && data_cnt_ff != 4'hf)
        data_cnt_ff <= data_cnt_ff + 4'h1;
      if (err_pulse && err_cnt_ff != 4'hf)
        err_cnt_ff <= err_cnt_ff + 4'h1;
    end
  end

  // ---------------------------------------------------------------
  // Power state machine and pulse burst
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {EDP_UP, EDP_DOWN} edp_state_t;
  edp_state_t state_ff;
  logic [2:0] pulses_ff;
  logic pulse_gap_ff;
  // Manual request outranks automatic conditions and ignores thresholds
  assign go_up = cfg_ff.en && state_ff == EDP_DOWN &&
    (man_req || (cfg_ff.auto_up && data_reach)); // [RL3] [RL5] [RL15]
  assign go_down = cfg_ff.en && state_ff == EDP_UP &&
    (man_req || (cfg_ff.auto_down && line_s.no_energy)); // [RL4] [RL5]

  always_ff @(posedge clock)
  begin
    if (sys_rst || !cfg_ff.en)
      state_ff <= EDP_UP; // [RL15]
    else if (go_up)
      state_ff <= EDP_UP;
    else if (go_down)
      state_ff <= EDP_DOWN;
  end

  // Pulses spaced by one idle cycle so each is a distinct edge
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      pulses_ff <= 3'h0;
      pulse_gap_ff <= 1'b0;
      pulse_out <= 1'b0;
    end
    else if (go_up)
    begin
      pulses_ff <= cfg_ff.burst_dis ? EDP_SINGLE_LEN : EDP_BURST_LEN; // [RL7]
      pulse_gap_ff <= 1'b0;
      pulse_out <= 1'b0;
    end
    else if (pulses_ff != 3'h0 && !pulse_gap_ff)
    begin
      pulse_out <= 1'b1; // [RL7]
      pulses_ff <= pulses_ff - 3'h1;
      pulse_gap_ff <= 1'b1;
    end
    else
    begin
      pulse_out <= 1'b0;
      pulse_gap_ff <= 1'b0;
    end
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
      driver_power_on <= 1'b1;
    else
      driver_power_on <= !cfg_ff.en || go_up ||
        (state_ff == EDP_UP && !go_down); // [RL15]
  end

  // ---------------------------------------------------------------
  // Threshold flags, clear on read with set winning
  // ---------------------------------------------------------------
  logic err_met_ff;
  logic data_met_ff;
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      err_met_ff <= 1'b0;
      data_met_ff <= 1'b0;
    end
    else
    begin
      if (cfg_ff.en && err_reach)
        err_met_ff <= 1'b1; // [RL9]
      else if (ctrl_rd)
        err_met_ff <= 1'b0; // [RL9]
      if (cfg_ff.en && data_reach)
        data_met_ff <= 1'b1; // [RL10]
      else if (ctrl_rd)
        data_met_ff <= 1'b0; // [RL10]
    end
  end

  // ---------------------------------------------------------------
  // Interrupt status and mask
  // ---------------------------------------------------------------
  logic [EDP_IRQ_W-1:0] irq_stat_ff;
  logic [EDP_IRQ_W-1:0] irq_mask_ff;
  logic [EDP_IRQ_W-1:0] irq_ev;
  assign irq_ev = {cfg_ff.en && err_reach, go_down, go_up};
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      irq_stat_ff <= '0;
      irq_mask_ff <= '0;
    end
    else
    begin
      // Write-one-to-clear, a new event in the same cycle survives
      if (reg_wr && reg_addr == EDP_ADDR_IRQ_STAT)
        irq_stat_ff <= (irq_stat_ff & ~reg_wdata[EDP_IRQ_W-1:0]) | irq_ev;
      else
        irq_stat_ff <= irq_stat_ff | irq_ev;
      if (reg_wr && reg_addr == EDP_ADDR_IRQ_MASK)
        irq_mask_ff <= reg_wdata[EDP_IRQ_W-1:0];
    end
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
      irq <= 1'b0;
    else
      irq <= |((irq_stat_ff | irq_ev) & irq_mask_ff);
  end

  // ---------------------------------------------------------------
  // Read port, one cycle latency, unmapped reads give zero
  // ---------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (sys_rst || !reg_rd)
      reg_rdata <= 16'h0;
    else
      unique case (reg_addr)
        EDP_ADDR_CTRL: reg_rdata <= {cfg_ff.en, cfg_ff.auto_up,
          cfg_ff.auto_down, 1'b0, cfg_ff.burst_dis,
          state_ff == EDP_UP, err_met_ff, data_met_ff,
          cfg_ff.err_thr, cfg_ff.data_thr}; // [RL8] [RL14]
        EDP_ADDR_IRQ_STAT: reg_rdata <= {13'h0, irq_stat_ff};
        EDP_ADDR_IRQ_MASK: reg_rdata <= {13'h0, irq_mask_ff};
        default: reg_rdata <= 16'h0;
      endcase
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  disabled_power_a: assert property (!cfg_ff.en |=> driver_power_on) // [RL15]
    else $error("driver off while energy detect disabled");
  manual_flip_a: assert property (man_req && cfg_ff.en &&
    state_ff == EDP_UP |=> state_ff == EDP_DOWN) // [RL5]
    else $error("manual request did not power down");
  auto_up_a: assert property (go_up |=> state_ff == EDP_UP ##1
    (pulse_out [*1])) // [RL3]
    else $error("power up did not start pulses");
  auto_down_a: assert property (cfg_ff.en && cfg_ff.auto_down &&
    state_ff == EDP_UP && line_s.no_energy && !man_req |=>
    !driver_power_on) // [RL4]
    else $error("no energy did not power down");
  single_pulse_a: assert property (go_up && cfg_ff.burst_dis |=>
    ##1 pulse_out ##1 !pulse_out [*4]) // [RL7]
    else $error("more than one pulse with burst disabled");
  state_read_a: assert property (ctrl_rd && !(go_up || go_down) |=>
    reg_rdata[EDP_BIT_PWR] == $past(state_ff == EDP_UP)) // [RL8]
    else $error("power state bit misreported");
  data_met_a: assert property (cfg_ff.en && data_reach |=>
    data_met_ff) // [RL10]
    else $error("data threshold flag not set");
  err_clear_a: assert property (ctrl_rd && !err_reach |=>
    !err_met_ff) // [RL9]
    else $error("error flag not cleared on read");
  idle_reset_a: assert property (idle_done |=> data_cnt_ff == 4'h0 &&
    err_cnt_ff == 4'h0) // [RL13]
    else $error("counters not reset after idle");
  thr_reset_a: assert property ($fell(strap_take_ff) |->
    cfg_ff.data_thr == EDP_DATA_THR_RST) // [RL12]
    else $error("data threshold reset value wrong");
  up_cover: cover property (go_up ##[1:10] pulse_out);
  down_cover: cover property (go_down);
  met_cover: cover property (err_met_ff && data_met_ff);
endmodule

// ===== hw/edp_pkg.sv
// Purpose: constants and types for the energy detect power control block
// Assumes: 125 MHz clock, 16-bit register port
// Notes: one register at 1Dh plus an interrupt status/mask pair
package edp_pkg;
  localparam logic [4:0] EDP_ADDR_CTRL = 5'h1d;
  localparam logic [4:0] EDP_ADDR_IRQ_STAT = 5'h1e;
  localparam logic [4:0] EDP_ADDR_IRQ_MASK = 5'h1f;
  localparam int EDP_BIT_EN = 15;
  localparam int EDP_BIT_AUTO_UP = 14;
  localparam int EDP_BIT_AUTO_DOWN = 13;
  localparam int EDP_BIT_MAN = 12;
  localparam int EDP_BIT_BURST_DIS = 11;
  localparam int EDP_BIT_PWR = 10;
  localparam int EDP_BIT_ERR_MET = 9;
  localparam int EDP_BIT_DATA_MET = 8;
  localparam logic [3:0] EDP_ERR_THR_RST = 4'h1;
  localparam logic [3:0] EDP_DATA_THR_RST = 4'h1;
  localparam logic EDP_AUTO_UP_RST = 1'b1;
  localparam logic EDP_AUTO_DOWN_RST = 1'b1;
  localparam logic [2:0] EDP_BURST_LEN = 3'h4;
  localparam logic [2:0] EDP_SINGLE_LEN = 3'h1;
  // Interrupt bit positions: 0 power up, 1 power down, 2 error met
  localparam int EDP_IRQ_W = 3;
  localparam int EDP_CLK_MHZ = 125;
  localparam int EDP_IDLE_MS = 2000;
  localparam longint EDP_IDLE_CYC = longint'(EDP_IDLE_MS) * 1000 * EDP_CLK_MHZ;
  localparam int EDP_SYNC_W = 3;
  typedef struct packed {
    logic en;
    logic auto_up;
    logic auto_down;
    logic burst_dis;
    logic [3:0] err_thr;
    logic [3:0] data_thr;
  } edp_cfg_t;
  typedef struct packed {
    logic data_ev;
    logic err_ev;
    logic no_energy;
  } edp_line_t;
endpackage

// ===== hw/edp_sync.sv
// Purpose: three-stage synchroniser with agreement filter for line inputs
// Assumes: inputs are asynchronous to clock
// Notes: a change counts once stages two and three agree
`timescale 1ns/1ps
module edp_sync
  import edp_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic async_in,
  output logic sync_out
);
  logic s1_ff;
  logic s2_ff;
  logic s3_ff;
  // Stage one feeds only stage two
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      s1_ff <= 1'b0;
      s2_ff <= 1'b0;
      s3_ff <= 1'b0;
      sync_out <= 1'b0;
    end
    else
    begin
      s1_ff <= async_in;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      if (s2_ff == s3_ff)
        sync_out <= s3_ff;
    end
  end
endmodule

// ===== bench/edp_link_model.sv
// Purpose: link partner on the cable for the energy detect block
// Assumes: line levels reach the block through its synchronisers
// Notes: the bench calls the tasks; pulses from the block are counted
`timescale 1ns/1ps
module edp_link_model
  import edp_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic pulse_out,
  output logic data_event_in,
  output logic error_event_in,
  output logic no_energy_in,
  output logic [7:0] pulses_seen
);
  // ----------------------------------------
  // Line stimulus
  // ----------------------------------------
  initial
  begin
    data_event_in = 1'b0;
    error_event_in = 1'b0;
    no_energy_in = 1'b0;
  end

  // Held four cycles so the agreement filter counts each event once
  task automatic send(input logic is_err, input int n, input int gap);
    for (int i = 0; i < n; i++)
    begin
      @(posedge clock);
      if (is_err) error_event_in <= 1'b1;
      else data_event_in <= 1'b1;
      repeat (4) @(posedge clock);
      error_event_in <= 1'b0;
      data_event_in <= 1'b0;
      repeat (gap) @(posedge clock);
    end
  endtask

  task automatic quiet(input logic q);
    @(posedge clock);
    no_energy_in <= q;
  endtask

  // ----------------------------------------
  // Pulse counter, as a far end would see the line
  // ----------------------------------------
  always_ff @(posedge clock)
  begin
    if (sys_rst) pulses_seen <= 8'h00;
    else if (pulse_out) pulses_seen <= pulses_seen + 8'h01;
  end
endmodule

// ===== bench/tb_energy_detect_power_control.sv
// Purpose: self-checking bench for the energy detect power control block
// Assumes: idle timeout shortened to 50 cycles, strap enables the block
// Notes: registers are reached through the plain strobe port
`timescale 1ns/1ps
module tb_energy_detect_power_control
  import edp_pkg::*;
;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic [4:0] reg_addr = 5'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic strap_en = 1'b1;
  logic [15:0] reg_rdata, r;
  logic driver_power_on, pulse_out, irq;
  logic data_event_in, error_event_in, no_energy_in;
  logic [7:0] pulses_seen, p0;
  int mismatches = 0;
  int checked = 0;
  int cycles = 0;

  // ----------------------------------------
  // Clock, timeout and instances
  // ----------------------------------------
  always #4 clock = ~clock;
  // Ceiling well above the few hundred cycles the scenarios need
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      summarize();
    end
  end

  edp_ctrl #(.IDLE_CYC(50)) edp_ctrl_inst (.clock(clock),
    .sys_rst(sys_rst), .strap_en(strap_en), .data_event_in(data_event_in),
    .error_event_in(error_event_in), .no_energy_in(no_energy_in),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .driver_power_on(driver_power_on), .pulse_out(pulse_out), .irq(irq));
  edp_link_model edp_link_model_inst (.clock(clock), .sys_rst(sys_rst),
    .pulse_out(pulse_out), .data_event_in(data_event_in),
    .error_event_in(error_event_in), .no_energy_in(no_energy_in),
    .pulses_seen(pulses_seen));

  // ----------------------------------------
  // Bus, wait and compare tasks
  // ----------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
    #1;
  endtask

  // Data stand only in the cycle after the strobe, so sample there
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  task automatic chk16(input logic [15:0] g, input logic [15:0] e);
    checked++;
    if (g !== e)
    begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask

  task automatic chk1(input logic g, input logic e);
    checked++;
    if (g !== e)
    begin
      mismatches++;
      $display("unexpected at %0t: flag %b want %b", $time, g, e);
    end
  endtask

  task automatic wdrv(input logic e, input int n);
    for (int i = 0; i < n && driver_power_on !== e; i++) tick(1);
    chk1(driver_power_on, e);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic s_reset_manual();
    rd(5'h1d, r);
    chk16(r, 16'he411);
    wr(5'h00, 16'hffff);
    rd(5'h00, r);
    chk16(r, 16'h0000);
    wr(5'h1d, 16'hf011);
    wdrv(1'b0, 6);
    rd(5'h1d, r);
    chk16(r, 16'he011);
  endtask

  task automatic s_auto_up();
    wr(5'h1d, 16'he013);
    p0 = pulses_seen;
    edp_link_model_inst.send(1'b0, 2, 3);
    tick(10);
    chk1(driver_power_on, 1'b0);
    edp_link_model_inst.send(1'b0, 1, 0);
    wdrv(1'b1, 20);
    tick(12);
    chk16({8'h00, pulses_seen - p0}, 16'h0004);
    rd(5'h1d, r);
    chk16(r, 16'he513);
    rd(5'h1d, r);
    chk16(r, 16'he413);
  endtask

  task automatic s_down_irq();
    wr(5'h1e, 16'h0007);
    wr(5'h1f, 16'h0002);
    edp_link_model_inst.quiet(1'b1);
    wdrv(1'b0, 20);
    tick(2);
    chk1(irq, 1'b1);
    rd(5'h1e, r);
    chk16(r, 16'h0002);
    wr(5'h1f, 16'h0000);
    tick(2);
    chk1(irq, 1'b0);
    wr(5'h1f, 16'h0002);
    tick(2);
    chk1(irq, 1'b1);
    wr(5'h1e, 16'h0002);
    tick(2);
    chk1(irq, 1'b0);
    rd(5'h1f, r);
    chk16(r, 16'h0002);
  endtask

  task automatic s_burst_err();
    edp_link_model_inst.quiet(1'b0);
    wr(5'h1e, 16'h0007);
    // Burst setting first: a manual command acts on the stored setting
    wr(5'h1d, 16'he813);
    p0 = pulses_seen;
    wr(5'h1d, 16'hf813);
    wdrv(1'b1, 6);
    tick(12);
    chk16({8'h00, pulses_seen - p0}, 16'h0001);
    wr(5'h1d, 16'he823);
    // A data event restarts the idle timer so both errors are counted
    edp_link_model_inst.send(1'b0, 1, 0);
    edp_link_model_inst.send(1'b1, 1, 0);
    tick(8);
    rd(5'h1d, r);
    chk16(r, 16'hec23);
    edp_link_model_inst.send(1'b1, 1, 0);
    tick(8);
    rd(5'h1d, r);
    chk16(r, 16'hee23);
    rd(5'h1d, r);
    chk16(r, 16'hec23);
    chk1(driver_power_on, 1'b1);
    rd(5'h1e, r);
    chk16(r, 16'h0005);
  endtask

  task automatic s_idle();
    wr(5'h1d, 16'hf822);
    wdrv(1'b0, 6);
    edp_link_model_inst.send(1'b0, 1, 0);
    tick(80);
    edp_link_model_inst.send(1'b0, 1, 0);
    tick(15);
    chk1(driver_power_on, 1'b0);
    edp_link_model_inst.send(1'b0, 1, 0);
    wdrv(1'b1, 20);
    rd(5'h1d, r);
    chk16(r, 16'hed22);
  endtask

  // Crossover control lives elsewhere, so nothing here touches it
  task automatic s_disable();
    wr(5'h1d, 16'hf822);
    wdrv(1'b0, 6);
    wr(5'h1d, 16'h6822);
    tick(2);
    chk1(driver_power_on, 1'b1);
    wr(5'h1d, 16'h7822);
    tick(6);
    chk1(driver_power_on, 1'b1);
    edp_link_model_inst.quiet(1'b1);
    tick(20);
    chk1(driver_power_on, 1'b1);
    rd(5'h1d, r);
    chk16(r & 16'hfbff, 16'h6822);
  endtask

  // Automatic bits cleared: neither line condition may move the state
  task automatic s_no_auto();
    wr(5'h1d, 16'h8822);
    tick(10);
    chk1(driver_power_on, 1'b1);
    edp_link_model_inst.send(1'b0, 1, 0);
    wr(5'h1d, 16'h9822);
    wdrv(1'b0, 6);
    edp_link_model_inst.send(1'b0, 2, 3);
    tick(10);
    chk1(driver_power_on, 1'b0);
    rd(5'h1d, r);
    chk16(r, 16'h8922);
  endtask

  // Second reset with the strap low leaves energy detect off
  task automatic s_strap();
    @(posedge clock);
    strap_en <= 1'b0;
    sys_rst <= 1'b1;
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    tick(2);
    chk1(driver_power_on, 1'b1);
    rd(5'h1d, r);
    chk16(r & 16'hfbff, 16'h6011);
  endtask

  // ----------------------------------------
  // Verdict and main sequence
  // ----------------------------------------
  task automatic summarize();
    if (mismatches == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  initial
  begin
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    tick(2);
    s_reset_manual();
    s_auto_up();
    s_down_irq();
    s_burst_err();
    s_idle();
    s_disable();
    s_no_auto();
    s_strap();
    summarize();
  end
endmodule
